// ===== ssq_pkg.sv
// Constants shared by the serial converter sequencer and its approximation register
package ssq_pkg;
  // Result width and code layout
  localparam int RES_W = 10;
  localparam int IDX_W = 4;
  localparam logic [IDX_W-1:0] MSB_IDX = 4'h9;
  localparam logic [RES_W-1:0] MSB_TRIAL = 10'h200;
  localparam logic [RES_W-1:0] CODE_RST = 10'h000;

  // Conversion cycle layout, in conversion clocks counted from 1
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CYC_NONE = 4'h0;
  localparam logic [CNT_W-1:0] CYC_FIRST = 4'h1;
  localparam logic [CNT_W-1:0] CYC_CAL_LAST = 4'h2;
  localparam logic [CNT_W-1:0] CYC_SAMPLE = 4'h3;
  localparam logic [CNT_W-1:0] CYC_BIT_FIRST = 4'h4;
  localparam logic [CNT_W-1:0] CYC_BIT_LAST = 4'hD;
  localparam logic [CNT_W-1:0] CYC_LEN = 4'hE;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    SSQ_IDLE = 2'b01,
    SSQ_CONV = 2'b10
  } ssq_state_e;
endpackage : ssq_pkg

// ===== ssq_sar.sv
// Successive-approximation register: trial code and decided bits
`timescale 1ns/100ps
module ssq_sar (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Control from the sequencer
  input wire logic load,
  input wire logic decide,
  input wire logic cmp_above,
  // Trial code to the DAC, and end of approximation
  output logic [ssq_pkg::RES_W-1:0] code_r,
  output logic done_r
);
  import ssq_pkg::*;

  logic [IDX_W-1:0] idx_r;

  // Load starts with only the top trial bit set; each decision keeps or drops
  // the current bit and raises the next lower one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_r <= CODE_RST;
      idx_r <= MSB_IDX;
      done_r <= 1'b0;
    end else if (ce) begin
      if (load) begin
        code_r <= MSB_TRIAL;
        idx_r <= MSB_IDX;
        done_r <= 1'b0;
      end else if (decide && !done_r) begin
        code_r[idx_r] <= cmp_above;
        if (idx_r != '0) begin
          code_r[IDX_W'(idx_r - 4'h1)] <= 1'b1;
          idx_r <= IDX_W'(idx_r - 4'h1);
        end else begin
          done_r <= 1'b1; // Lowest bit decided
        end
      end
    end
  end
endmodule : ssq_sar

// ===== ssq_sequencer.sv
// Conversion sequencer and serial result output of a 10-bit SAR converter
`timescale 1ns/100ps
module ssq_sequencer (
  // System clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Host side pins, already synchronous to clk
  input wire logic conv_clk,
  input wire logic conversion_start_n,
  // Analog front end
  input wire logic cmp_above,
  output logic [ssq_pkg::RES_W-1:0] dac_code,
  output logic cal_en_r,
  output logic hold_r,
  // Serial data pin
  output logic data_out_r,
  output logic data_oe_r,
  // Status and parallel result
  output logic busy_r,
  output logic [ssq_pkg::RES_W-1:0] result_r,
  output logic result_valid_r
);
  import ssq_pkg::*;

  // True for the conversion clocks whose falling edge decides a bit
  // (clocks 4 to 13; the falling edge of clock 14 only closes the cycle)
  function automatic logic in_bit_window(input logic [CNT_W-1:0] n);
    in_bit_window = (n >= CYC_BIT_FIRST) && (n <= CYC_BIT_LAST);
  endfunction : in_bit_window

  ssq_state_e state_r;
  logic [CNT_W-1:0] clk_no_r;
  logic conv_prev_r;
  logic chain_r;
  logic rise;
  logic fall;
  logic start_cycle;
  logic sar_load;
  logic sar_decide;
  logic lsb_end;
  logic cycle_exit;
  logic [RES_W-1:0] sar_code;

  // Edges of the host conversion clock seen in the system clock domain
  assign rise = conv_clk & ~conv_prev_r;
  assign fall = ~conv_clk & conv_prev_r;

  // A cycle opens on a rise when idle with start low, or when chained
  assign start_cycle = rise && (((state_r == SSQ_IDLE) && !conversion_start_n)
                       || ((state_r == SSQ_CONV) && (clk_no_r == CYC_LEN)));
  assign sar_load = start_cycle;
  assign sar_decide = fall && (state_r == SSQ_CONV) && in_bit_window(clk_no_r);

  // Leading edge of clock 14 ends the LSB; its falling edge closes a single-shot
  // cycle. Several processes act on both, so they are decoded once here and
  // cannot drift apart
  assign lsb_end = rise && (state_r == SSQ_CONV) && (clk_no_r == CYC_BIT_LAST);
  assign cycle_exit = fall && (state_r == SSQ_CONV) && (clk_no_r == CYC_LEN)
                      && !chain_r && conversion_start_n;

  // Previous sample of the host clock. Each host clock phase must last at
  // least one system clock or an edge is missed; that is the price of
  // running everything on one clock instead of on the host clock itself
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_prev_r <= 1'b0;
    end else if (ce) begin
      conv_prev_r <= conv_clk;
    end
  end

  // Sequencer state and conversion clock count; the count only advances on
  // host clock edges, so a stopped clock between cycles costs nothing.
  // A clock stopped inside a cycle freezes the count where it stands, since
  // no timer runs here; the cycle resumes on the next edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= SSQ_IDLE;
      clk_no_r <= CYC_NONE;
    end else if (ce) begin
      unique case (state_r)
        SSQ_IDLE: begin
          if (start_cycle) begin
            state_r <= SSQ_CONV;
            clk_no_r <= CYC_FIRST;
          end
        end
        SSQ_CONV: begin
          if (start_cycle) begin
            clk_no_r <= CYC_FIRST;
          end else if (rise && clk_no_r < CYC_LEN) begin
            clk_no_r <= CNT_W'(clk_no_r + 4'h1);
          end else if (cycle_exit) begin
            state_r <= SSQ_IDLE;
            clk_no_r <= CYC_NONE;
          end
        end
        default: begin
          state_r <= SSQ_IDLE;
          clk_no_r <= CYC_NONE;
        end
      endcase
    end
  end

  // Remember a start request seen during clock 14, up to its trailing edge.
  // A short low pulse inside clock 14 must still chain the next cycle, even
  // though the line is high again when the clock falls
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chain_r <= 1'b0;
    end else if (ce) begin
      if (start_cycle) begin
        chain_r <= 1'b0;
      end else if (state_r == SSQ_CONV && clk_no_r == CYC_LEN && !conversion_start_n) begin
        chain_r <= 1'b1;
      end
    end
  end

  // Calibration over the first two clocks, hold from the third falling edge
  // until clock 14 opens, when tracking for the next sample resumes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_en_r <= 1'b0;
      hold_r <= 1'b0;
    end else if (ce) begin
      if (start_cycle) begin
        cal_en_r <= 1'b1;
        hold_r <= 1'b0;
      end else if (state_r == SSQ_CONV) begin
        if (rise && clk_no_r == CYC_CAL_LAST) begin
          cal_en_r <= 1'b0;
        end
        if (fall && clk_no_r == CYC_SAMPLE) begin
          hold_r <= 1'b1;
        end else if (lsb_end) begin
          hold_r <= 1'b0;
        end
      end else begin
        cal_en_r <= 1'b0;
        hold_r <= 1'b0;
      end
    end
  end

  // Serial data pin. Each bit is the comparator decision taken at the same
  // falling edge, so the pin never waits on the SAR register; the LSB is cut
  // at the leading edge of clock 14, one clock before the next cycle may begin
  // (the host must catch it within that one low phase)
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_out_r <= 1'b0;
      data_oe_r <= 1'b0;
    end else if (ce) begin
      if (start_cycle) begin
        data_out_r <= 1'b0;
        data_oe_r <= 1'b1;
      end else if (sar_decide) begin
        data_out_r <= cmp_above;
      end else if (lsb_end) begin
        data_out_r <= 1'b0;
      end else if (cycle_exit) begin
        data_oe_r <= 1'b0;
      end
    end
  end

  // Status and parallel copy of the finished result. busy_r also covers the
  // start edge itself, so it rises with data_oe_r and cal_en_r when a cycle opens from idle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      result_r <= CODE_RST;
      result_valid_r <= 1'b0;
    end else if (ce) begin
      busy_r <= (state_r == SSQ_CONV) || start_cycle;
      result_valid_r <= 1'b0;
      if (sar_decide && clk_no_r == CYC_BIT_LAST) begin
        result_r <= {sar_code[RES_W-1:1], cmp_above};
        result_valid_r <= 1'b1;
      end
    end
  end

  // Trial code register; the DAC follows it directly. Its end flag is left
  // open: the conversion clock count already marks the last decision
  ssq_sar u_sar (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .load(sar_load),
    .decide(sar_decide),
    .cmp_above(cmp_above),
    .code_r(sar_code),
    .done_r()
  );

  assign dac_code = sar_code;

endmodule : ssq_sequencer

// ===== ssq_seq_properties.sv
// Port-level checks of the conversion sequencer
`timescale 1ns/100ps
module ssq_seq_props (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Host pins and comparator
  input wire logic conv_clk,
  input wire logic conversion_start_n,
  input wire logic cmp_above,
  // Watched outputs
  input wire logic [ssq_pkg::RES_W-1:0] dac_code,
  input wire logic cal_en_r,
  input wire logic hold_r,
  input wire logic data_out_r,
  input wire logic data_oe_r,
  input wire logic busy_r,
  input wire logic [ssq_pkg::RES_W-1:0] result_r,
  input wire logic result_valid_r
);
  import ssq_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // A new cycle drives zero, never a stale bit
  a_open_low: assert property ($rose(data_oe_r) |-> !data_out_r) else $error("pin not low");
  a_start_idle: assert property (!busy_r && $rose(conv_clk) && !conversion_start_n |=> busy_r)
    else $error("no start");
  a_cal_first: assert property ($rose(busy_r) |-> cal_en_r && !hold_r) else $error("no cal");
  a_dac_msb: assert property ($rose(busy_r) |-> dac_code == MSB_TRIAL) else $error("bad trial");
  a_lsb_out: assert property (result_valid_r |-> data_out_r == result_r[0]) else $error("lsb");
  a_valid_pulse: assert property (result_valid_r |=> !result_valid_r) else $error("long pulse");
  a_float_idle: assert property (!busy_r |-> !data_oe_r) else $error("pin driven idle");
  a_end_idle: assert property ($fell(data_oe_r) |=> !busy_r) else $error("busy stuck");
  a_oe_busy: assert property (data_oe_r |-> busy_r) else $error("pin off cycle");
  a_hold_conv: assert property (hold_r |-> busy_r && !cal_en_r)
    else $error("hold out of place");
  a_hold_fall: assert property ($rose(hold_r) |-> !conv_clk && $past(conv_clk, 2))
    else $error("hold not at fall");
  // Main scenarios
  c_single: cover property ($fell(data_oe_r));
  c_chain: cover property (busy_r && $past(busy_r) && $rose(cal_en_r));
  c_full: cover property (result_valid_r && result_r == 10'h03ff);
endmodule : ssq_seq_props

// ===== ssq_host_model.sv
// Host serial port model: conversion clock source and bit latch
`timescale 1ns/100ps
module ssq_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Clock gate and data pin
  input wire logic run,
  input wire logic data_out_r,
  input wire logic data_oe_r,
  // Conversion clock and latched bits
  output logic conv_clk,
  output logic [ssq_pkg::RES_W-1:0] rx_bits_r
);
  import ssq_pkg::*;
  logic [1:0] ph_r;
  // Four system clocks a phase; the clock only stops low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_r <= 2'h0;
      conv_clk <= 1'b0;
    end else if (run || conv_clk) begin
      ph_r <= ph_r + 2'h1;
      if (ph_r == 2'h3) conv_clk <= !conv_clk;
    end
  end
  // Latch at the rising edge, while the short LSB is still held
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rx_bits_r <= 10'h0000;
    else if (ph_r == 2'h3 && !conv_clk && run)
      rx_bits_r <= {rx_bits_r[8:0], data_oe_r ? data_out_r : !rx_bits_r[0]};
  end
endmodule : ssq_host_model

// ===== serial_sar_adc_sequencer_tb_top.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module serial_sar_adc_sequencer_tb_top;
  import ssq_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic conversion_start_n = 1'b1;
  logic cmp_above = 1'b0;
  logic [9:0] ain = 10'h0000;
  logic conv_clk, cal_en_r, hold_r, data_out_r, data_oe_r, busy_r, result_valid_r;
  logic [9:0] dac_code, result_r, rx_bits_r;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int exp_q[$];
  logic run = 1'b1;
  int prev_mode = 0;
  int t_last = 0;
  // Host conversion clock period in system clocks
  localparam int CONV_PER = 8;
  always #2 clk = !clk;
  // Ideal comparator; registered so it is driven at the edge
  always @(posedge clk) cmp_above <= (ain >= dac_code);
  ssq_sequencer dut (.clk, .sys_rst, .ce(1'b1), .conv_clk, .conversion_start_n, .cmp_above,
    .dac_code, .cal_en_r, .hold_r, .data_out_r, .data_oe_r, .busy_r, .result_r, .result_valid_r);
  ssq_host_model host (.clk, .sys_rst, .run, .data_out_r, .data_oe_r, .conv_clk,
    .rx_bits_r);
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic final_report;
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // One conversion. Mode 0 single shot, 1 start held low (free run), 2 start
  // released mid-cycle and pulsed low inside clock 14 (synchronous chaining)
  task automatic frame(input logic [9:0] a, input int mode);
    int e;
    int t;
    @(posedge clk);
    ain <= a;
    conversion_start_n <= 1'b0;
    exp_q.push_back(a);
    if (mode == 2) begin
      repeat (20) @(posedge clk);
      conversion_start_n <= 1'b1;
    end
    repeat (400) begin
      @(negedge clk);
      if (result_valid_r === 1'b1) break;
    end
    t = cyc;
    e = exp_q.pop_front();
    chk("result", 10'(e), result_r);
    if (prev_mode != 0) chk("period", 10'(14 * CONV_PER), 10'(t - t_last));
    t_last = t;
    prev_mode = mode;
    @(posedge clk);
    conversion_start_n <= (mode != 1);
    repeat (4) @(negedge clk);
    chk("serial", 10'(e), rx_bits_r);
    @(posedge clk);
    if (mode == 2) conversion_start_n <= 1'b0;
    @(posedge clk);
    conversion_start_n <= (mode != 1);
    repeat (4) @(negedge clk);
    chk("pin", {7'h00, mode != 0, mode != 0, 1'b0},
      {7'h00, busy_r, data_oe_r, data_out_r});
  endtask : frame
  // Hang guard, about three times the planned run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'h6b4e));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      frame(i == 0 ? 10'h03ff : i == 1 ? 10'h0000 : 10'($urandom),
        i < 3 ? 1 : i < 5 ? 2 : 0);
    // Host clock stopped between cycles with start pending: nothing may move
    @(posedge clk);
    run <= 1'b0;
    repeat (12) @(posedge clk);
    conversion_start_n <= 1'b0;
    repeat (40) @(negedge clk);
    chk("stopped", 10'h000, {8'h00, busy_r, data_oe_r});
    @(posedge clk);
    run <= 1'b1;
    frame(10'($urandom), 0);
    final_report();
  end
endmodule : serial_sar_adc_sequencer_tb_top
bind ssq_sequencer ssq_seq_props u_props (.clk, .sys_rst, .ce, .conv_clk, .conversion_start_n,
  .cmp_above, .dac_code, .cal_en_r, .hold_r, .data_out_r, .data_oe_r, .busy_r, .result_r,
  .result_valid_r);
